/* verilog/rcp_radio_port.sv */
// Radio control port: special-function registers for the radio and ADC subsystem.
// Assumes one-cycle SFR read/write strobes on sys_clk and a hardware serial
// master on the same clock; subsystem status lines arrive asynchronously.
//
// Function
// - Selector: 00 off, 01 boot, 1x radio.
// - Read bits 7..4: match, carrier, ready, conversion.
// - Read bit 2 serial data; 3,1,0 zero.
// - Write bit5 chip enable, bit4 transmit select.
// - Write bits 3,1,0: select, data, clock.
// - Upper selector bit: master owns serial pins.
// - Upper bit clear: lines follow port bits directly.
// - Reset forces control outputs to defaults.
// - Defaults hold until software writes port or selector.
// - Port latch resets with chip select high.
// - Mode from chip enable and transmit select.
// - Receive: match and ready flag arrivals.
// - Transmit: radio adds preamble and checksum.
// - Transmit: ready marks transmission complete.
// - Port is not bidirectional.
// - Ready and match drop after payload read.
// - Transmit finishes packet before entering standby.
`timescale 1ns/10ps
module rcp_radio_port (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrRdEn,
  output logic      [7:0] sfrRdData,
  input  wire logic       addressMatch,
  input  wire logic       carrierDetect,
  input  wire logic       radioDataReady,
  input  wire logic       adcEndOfConv,
  input  wire logic       radioSerialDataOut,
  input  wire logic       bootSerialDataOut,
  input  wire logic       masterClock,
  input  wire logic       masterDataOut,
  output logic            masterDataIn,
  output logic            radioChipEnable,
  output logic            radioTxSelect,
  output logic            radioSerialSelect,
  output logic            radioSerialDataIn,
  output logic            radioSerialClock,
  output logic            bootSerialClock,
  output logic            bootSerialDataIn,
  output logic      [1:0] radioMode
);

  logic [7:0]                    portLatch_reg;
  logic [7:0]                    portLatch_next;
  logic [1:0]                    routeSel_reg;
  logic [rcp_pkg::RCP_SYNC_W-1:0] statusSync;
  logic                          amSync;
  logic                          cdSync;
  logic                          drSync;
  logic                          eocSync;
  logic                          radioMisoSync;
  logic                          bootMisoSync;
  logic                          drPrev_reg;
  logic                          drRise;
  logic                          radioClockNext;
  logic                          radioDataInNext;
  logic                          bootClockNext;
  logic                          bootDataInNext;
  logic                          masterDataInNext;
  logic                          portWrite;
  logic                          routeWrite;
  logic                          wroteSinceReset_reg;
  rcp_pkg::rcp_mode_t            mode_reg;
  rcp_pkg::rcp_mode_t            mode_next;

  assign portWrite  = sfrWrEn && (sfrAddr == rcp_pkg::RCP_RADIO_PORT_ADDR);
  assign routeWrite = sfrWrEn && (sfrAddr == rcp_pkg::RCP_ROUTE_SEL_ADDR);

  // Status lines come from the analog subsystem, so they are synchronised first.
  rcp_sync2 #(
    .WIDTH (rcp_pkg::RCP_SYNC_W)
  ) u_status_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn ({addressMatch, carrierDetect, radioDataReady, adcEndOfConv,
               radioSerialDataOut, bootSerialDataOut}),
    .syncOut (statusSync)
  );

  assign {amSync, cdSync, drSync, eocSync, radioMisoSync, bootMisoSync} = statusSync;

  rcp_route_mux u_route_mux (
    .routeSel         (routeSel_reg),
    .latchClock       (portLatch_reg[rcp_pkg::RCP_BIT_SCK]),
    .latchDataIn      (portLatch_reg[rcp_pkg::RCP_BIT_MOSI]),
    .masterClock      (masterClock),
    .masterDataOut    (masterDataOut),
    .radioMisoSync    (radioMisoSync),
    .bootMisoSync     (bootMisoSync),
    .radioClockNext   (radioClockNext),
    .radioDataInNext  (radioDataInNext),
    .bootClockNext    (bootClockNext),
    .bootDataInNext   (bootDataInNext),
    .masterDataInNext (masterDataInNext)
  );

  // Read-only bits never store anything, so the latch cannot echo status back.
  always_comb
  begin
    portLatch_next = portLatch_reg;
    if (portWrite)
    begin
      portLatch_next = (portLatch_reg & ~rcp_pkg::RCP_PORT_WR_MASK)
                     | (sfrWrData & rcp_pkg::RCP_PORT_WR_MASK);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      portLatch_reg <= rcp_pkg::RCP_RADIO_PORT_RST;
    end
    else
    begin
      portLatch_reg <= portLatch_next;
    end
  end

  // The selector only steers the mux; the latch keeps its value across a change.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      routeSel_reg <= rcp_pkg::RCP_ROUTE_SEL_RST;
    end
    else if (routeWrite)
    begin
      routeSel_reg <= sfrWrData[1:0];
    end
  end

  // Control outputs are registered so that each pin comes from a flip-flop.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      radioChipEnable   <= rcp_pkg::RCP_RADIO_PORT_RST[rcp_pkg::RCP_BIT_CE];
      radioTxSelect     <= rcp_pkg::RCP_RADIO_PORT_RST[rcp_pkg::RCP_BIT_TXS];
      radioSerialSelect <= rcp_pkg::RCP_RADIO_PORT_RST[rcp_pkg::RCP_BIT_CSN];
      radioSerialDataIn <= rcp_pkg::RCP_RADIO_PORT_RST[rcp_pkg::RCP_BIT_MOSI];
      radioSerialClock  <= rcp_pkg::RCP_RADIO_PORT_RST[rcp_pkg::RCP_BIT_SCK];
    end
    else
    begin
      radioChipEnable   <= portLatch_reg[rcp_pkg::RCP_BIT_CE];
      radioTxSelect     <= portLatch_reg[rcp_pkg::RCP_BIT_TXS];
      radioSerialSelect <= portLatch_reg[rcp_pkg::RCP_BIT_CSN];
      radioSerialDataIn <= radioDataInNext;
      radioSerialClock  <= radioClockNext;
    end
  end

  // The serial clock is whatever software or the master toggles; no rate is imposed.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bootSerialClock  <= 1'h0;
      bootSerialDataIn <= 1'h0;
      masterDataIn     <= 1'h0;
    end
    else
    begin
      bootSerialClock  <= bootClockNext;
      bootSerialDataIn <= bootDataInNext;
      masterDataIn     <= masterDataInNext;
    end
  end

  // Read data is captured at the read strobe and held until the next read.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfrRdData <= 8'h00;
    end
    else if (sfrRdEn)
    begin
      case (sfrAddr)
        rcp_pkg::RCP_RADIO_PORT_ADDR:
        begin
          sfrRdData <= {amSync, cdSync, drSync, eocSync, 1'h0, radioMisoSync,
                        2'h0};
        end
        rcp_pkg::RCP_ROUTE_SEL_ADDR:
        begin
          sfrRdData <= {6'h00, routeSel_reg};
        end
        default:
        begin
          sfrRdData <= 8'h00;
        end
      endcase
    end
  end

  // Ready and match are not latched here, so the radio clearing them shows after the two synchroniser stages.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      drPrev_reg <= 1'h0;
    end
    else
    begin
      drPrev_reg <= drSync;
    end
  end

  assign drRise = drSync && !drPrev_reg;

  // Mode tracker; preamble and checksum are added inside the radio itself.
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      rcp_pkg::RCP_STANDBY, rcp_pkg::RCP_BURST_RX:
      begin
        if (!radioChipEnable)
        begin
          mode_next = rcp_pkg::RCP_STANDBY;
        end
        else if (radioTxSelect)
        begin
          mode_next = rcp_pkg::RCP_BURST_TX;
        end
        else
        begin
          mode_next = rcp_pkg::RCP_BURST_RX;
        end
      end
      rcp_pkg::RCP_BURST_TX:
      begin
        // A packet under way always completes; ready marks its end.
        if (drRise)
        begin
          if (!radioChipEnable)
          begin
            mode_next = rcp_pkg::RCP_STANDBY;
          end
          else if (!radioTxSelect)
          begin
            mode_next = rcp_pkg::RCP_BURST_RX;
          end
        end
      end
      default:
      begin
        mode_next = rcp_pkg::RCP_STANDBY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_reg  <= rcp_pkg::RCP_STANDBY;
      radioMode <= 2'h0;
    end
    else
    begin
      mode_reg  <= mode_next;
      radioMode <= mode_next;
    end
  end

  // Helper for the assertions: has software written the port since reset.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wroteSinceReset_reg <= 1'h0;
    end
    else if (portWrite)
    begin
      wroteSinceReset_reg <= 1'h1;
    end
  end

  a_route_radio_pins: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    routeSel_reg[rcp_pkg::RCP_ROUTE_RADIO_BIT]
      |=> (radioSerialClock == $past(masterClock))
          && (radioSerialDataIn == $past(masterDataOut)))
    else $error("Radio serial pins not owned by the serial master.");

  a_route_latch_pins: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !routeSel_reg[rcp_pkg::RCP_ROUTE_RADIO_BIT]
      |=> (radioSerialClock == $past(portLatch_reg[rcp_pkg::RCP_BIT_SCK]))
          && (radioSerialDataIn == $past(portLatch_reg[rcp_pkg::RCP_BIT_MOSI])))
    else $error("Radio serial pins do not follow the port latch.");

  a_route_boot_pins: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (routeSel_reg == rcp_pkg::RCP_ROUTE_BOOT)
      |=> (bootSerialClock == $past(masterClock)) && (masterDataIn == $past(bootMisoSync)))
    else $error("Boot pins not connected to the serial master.");

  a_route_off_pins: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (routeSel_reg == rcp_pkg::RCP_ROUTE_OFF) |=> !bootSerialClock && !masterDataIn)
    else $error("Serial master not disconnected.");
  a_read_status: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (sfrRdEn && (sfrAddr == rcp_pkg::RCP_RADIO_PORT_ADDR))
      |=> (sfrRdData[7:4] == $past({amSync, cdSync, drSync, eocSync})))
    else $error("Status bits read back wrong.");

  a_read_zero_bits: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (sfrRdEn && (sfrAddr == rcp_pkg::RCP_RADIO_PORT_ADDR))
      |=> !sfrRdData[3] && (sfrRdData[1:0] == 2'h0)
          && (sfrRdData[2] == $past(radioMisoSync)))
    else $error("Unused port bits or serial data read wrong.");
  a_write_ctrl: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    portWrite ##1 !portWrite
      |=> (radioChipEnable == $past(sfrWrData[rcp_pkg::RCP_BIT_CE], 2))
          && (radioTxSelect == $past(sfrWrData[rcp_pkg::RCP_BIT_TXS], 2)))
    else $error("Chip enable or transmit select not driven by write.");

  a_write_select: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    portWrite ##1 !portWrite
      |=> (radioSerialSelect == $past(sfrWrData[rcp_pkg::RCP_BIT_CSN], 2)))
    else $error("Serial select not driven by write.");
  a_no_echo_bits: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ((portLatch_reg & ~rcp_pkg::RCP_PORT_WR_MASK) == 8'h00))
    else $error("Read-only port bits were stored.");

  a_hold_defaults: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    !wroteSinceReset_reg ##1 !wroteSinceReset_reg
      |-> radioSerialSelect && !radioChipEnable && !radioTxSelect)
    else $error("Control outputs left their defaults before a write.");

  a_mode_standby: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (!radioChipEnable && (mode_reg != rcp_pkg::RCP_BURST_TX))
      |=> (mode_reg == rcp_pkg::RCP_STANDBY))
    else $error("Mode not standby with chip enable low.");
  a_tx_finish: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    ((mode_reg == rcp_pkg::RCP_BURST_TX) && !drRise) |=> (mode_reg == rcp_pkg::RCP_BURST_TX))
    else $error("Transmit left before completion.");

  a_route_keeps_latch: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    (routeWrite && !portWrite) |=> $stable(portLatch_reg))
    else $error("Selector change corrupted the port latch.");

endmodule // rcp_radio_port

/* verilog/rcp_pkg.sv */
// Constants and types shared by the radio control port and its helpers.
// Assumes an 8051-style special-function register bus clocked by sys_clk.
package rcp_pkg;

  // Special-function register addresses.
  localparam logic [7:0] RCP_RADIO_PORT_ADDR  = 8'hA0;
  localparam logic [7:0] RCP_ROUTE_SEL_ADDR   = 8'hB3;

  // Reset values; the chip-select bit of the port latch comes up high.
  localparam logic [7:0] RCP_RADIO_PORT_RST   = 8'h08;
  localparam logic [1:0] RCP_ROUTE_SEL_RST    = 2'h0;

  // Only these latch bits respond to a write.
  localparam logic [7:0] RCP_PORT_WR_MASK     = 8'h3B;

  // Read-side bit positions of the radio port.
  localparam int RCP_BIT_AM   = 7;
  localparam int RCP_BIT_CD   = 6;
  localparam int RCP_BIT_DR   = 5;
  localparam int RCP_BIT_EOC  = 4;
  localparam int RCP_BIT_MISO = 2;

  // Write-side bit positions of the radio port.
  localparam int RCP_BIT_CE   = 5;
  localparam int RCP_BIT_TXS  = 4;
  localparam int RCP_BIT_CSN  = 3;
  localparam int RCP_BIT_MOSI = 1;
  localparam int RCP_BIT_SCK  = 0;

  // Serial routing selector codes; the upper bit alone selects the radio side.
  localparam logic [1:0] RCP_ROUTE_OFF        = 2'h0;
  localparam logic [1:0] RCP_ROUTE_BOOT       = 2'h1;
  localparam int         RCP_ROUTE_RADIO_BIT  = 1;

  // Width of the status synchroniser: am, cd, dr, eoc, radio miso, boot miso.
  localparam int RCP_SYNC_W = 6;

  typedef enum logic [1:0] {RCP_STANDBY, RCP_BURST_RX, RCP_BURST_TX} rcp_mode_t;

endpackage

/* verilog/rcp_sync2.sv */
// Two flip-flop synchroniser for a group of independent level signals.
// Assumes each bit changes slowly relative to sys_clk; bits are not coherent.
`timescale 1ns/10ps
module rcp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule // rcp_sync2

/* verilog/rcp_route_mux.sv */
// Pin ownership selector between the port latch and the hardware serial master.
// Assumes all inputs are on sys_clk; the caller registers every output.
`timescale 1ns/10ps
module rcp_route_mux (
  input  wire logic [1:0] routeSel,
  input  wire logic       latchClock,
  input  wire logic       latchDataIn,
  input  wire logic       masterClock,
  input  wire logic       masterDataOut,
  input  wire logic       radioMisoSync,
  input  wire logic       bootMisoSync,
  output logic            radioClockNext,
  output logic            radioDataInNext,
  output logic            bootClockNext,
  output logic            bootDataInNext,
  output logic            masterDataInNext
);

  always_comb
  begin
    radioClockNext   = latchClock;
    radioDataInNext  = latchDataIn;
    bootClockNext    = 1'h0;
    bootDataInNext   = 1'h0;
    masterDataInNext = 1'h0;
    if (routeSel[rcp_pkg::RCP_ROUTE_RADIO_BIT])
    begin
      radioClockNext   = masterClock;
      radioDataInNext  = masterDataOut;
      masterDataInNext = radioMisoSync;
    end
    else if (routeSel == rcp_pkg::RCP_ROUTE_BOOT)
    begin
      bootClockNext    = masterClock;
      bootDataInNext   = masterDataOut;
      masterDataInNext = bootMisoSync;
    end
  end

endmodule // rcp_route_mux

/* sim/rcp_radio_model.sv */
// Behavioural model of the radio and converter subsystem behind the control port.
// Assumes its control inputs are the port's registered outputs on sys_clk.
`timescale 1ns/10ps
module rcp_radio_model #(
  parameter int         TX_CYCLES = 40,
  parameter logic [7:0] PATTERN   = 8'hA5
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic chipEnable,
  input  wire logic txSelect,
  input  wire logic serialSelect,
  input  wire logic serialClock,
  input  wire logic carrierOn,
  input  wire logic eocOn,
  input  wire logic packetOn,
  output logic      addressMatch,
  output logic      carrierDetect,
  output logic      dataReady,
  output logic      endOfConv,
  output logic      serialDataOut
);
  logic [7:0] shiftReg;
  logic [7:0] txCount;
  logic       txBusy;
  logic       sckLast;
  logic       csnLast;
  logic       fillBit;

  // Carrier is only sensed while receiving.
  assign carrierDetect = chipEnable & ~txSelect & carrierOn;
  assign endOfConv     = eocOn;
  // A released data line toggles so that a stale value can never pass a check.
  assign serialDataOut = serialSelect ? fillBit : shiftReg[7];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shiftReg     <= PATTERN;
      txCount      <= 8'h00;
      txBusy       <= 1'b0;
      sckLast      <= 1'b0;
      csnLast      <= 1'b1;
      fillBit      <= 1'b0;
      addressMatch <= 1'b0;
      dataReady    <= 1'b0;
    end
    else
    begin
      sckLast <= serialClock;
      csnLast <= serialSelect;
      fillBit <= ~fillBit;
      // Any clock rate is accepted; bits advance on each sampled rising clock.
      if (serialSelect)
        shiftReg <= PATTERN;
      else if (serialClock && !sckLast)
        shiftReg <= {shiftReg[6:0], shiftReg[7]};
      if (chipEnable && !txSelect && packetOn)
        addressMatch <= 1'b1;
      if (addressMatch && chipEnable && !txSelect)
        dataReady <= 1'b1;
      if (chipEnable && txSelect && !txBusy && !dataReady)
        txBusy <= 1'b1;
      // The packet always runs to its end, whatever chip enable does meanwhile.
      if (txBusy)
      begin
        txCount <= txCount + 8'h01;
        if (txCount == 8'(TX_CYCLES - 1))
        begin
          txBusy    <= 1'b0;
          txCount   <= 8'h00;
          dataReady <= 1'b1;
        end
      end
      if (serialSelect && !csnLast)
      begin
        addressMatch <= 1'b0;
        dataReady    <= 1'b0;
      end
    end
  end
endmodule // rcp_radio_model

/* sim/test_radio_control_port.sv */
// Self-checking bench for the radio control port with a radio subsystem model.
// Assumes the design files and package are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin badCount++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module test_radio_control_port;
  localparam logic [7:0] PATTERN = 8'hA5;
  localparam logic [7:0] PORT    = rcp_pkg::RCP_RADIO_PORT_ADDR;
  localparam logic [7:0] ROUTE   = rcp_pkg::RCP_ROUTE_SEL_ADDR;
  localparam logic [7:0] RSTV    = rcp_pkg::RCP_RADIO_PORT_RST;
  logic       sys_clk;
  logic       nrst = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic       sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic       sfrRdEn = 1'b0;
  logic [7:0] sfrRdData;
  logic       addressMatch, carrierDetect, radioDataReady, adcEndOfConv, radioSerialDataOut;
  logic       bootSerialDataOut = 1'b0;
  logic       masterClock = 1'b0;
  logic       masterDataOut = 1'b0;
  logic       masterDataIn, radioChipEnable, radioTxSelect, radioSerialSelect;
  logic       radioSerialDataIn, radioSerialClock, bootSerialClock, bootSerialDataIn;
  logic [1:0] radioMode;
  logic       carrierOn = 1'b0;
  logic       eocOn = 1'b0;
  logic       packetOn = 1'b0;
  logic [4:0] pins;
  logic [7:0] rd;
  logic [31:0] seed = 32'h0000DA69;
  logic [1:0] routes [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  int         badCount = 0;
  int         checksDone = 0;

  assign pins = {radioChipEnable, radioTxSelect, radioSerialSelect, radioSerialDataIn,
                 radioSerialClock};

  rcp_radio_port dut (
    .sys_clk(sys_clk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .addressMatch(addressMatch), .carrierDetect(carrierDetect),
    .radioDataReady(radioDataReady), .adcEndOfConv(adcEndOfConv),
    .radioSerialDataOut(radioSerialDataOut), .bootSerialDataOut(bootSerialDataOut),
    .masterClock(masterClock), .masterDataOut(masterDataOut), .masterDataIn(masterDataIn),
    .radioChipEnable(radioChipEnable), .radioTxSelect(radioTxSelect),
    .radioSerialSelect(radioSerialSelect), .radioSerialDataIn(radioSerialDataIn),
    .radioSerialClock(radioSerialClock), .bootSerialClock(bootSerialClock),
    .bootSerialDataIn(bootSerialDataIn), .radioMode(radioMode)
  );

  rcp_radio_model #(.TX_CYCLES(40), .PATTERN(PATTERN)) radio (
    .sys_clk(sys_clk), .nrst(nrst), .chipEnable(radioChipEnable), .txSelect(radioTxSelect),
    .serialSelect(radioSerialSelect), .serialClock(radioSerialClock), .carrierOn(carrierOn),
    .eocOn(eocOn), .packetOn(packetOn), .addressMatch(addressMatch),
    .carrierDetect(carrierDetect), .dataReady(radioDataReady), .endOfConv(adcEndOfConv),
    .serialDataOut(radioSerialDataOut)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [4:0] expPins(input logic [7:0] d);
    return {d[5], d[4], d[3], d[1], d[0]};
  endfunction

  task automatic tick();
    @(posedge sys_clk);
    #2;
  endtask

  // Each access lets one idle edge pass so a strobe is never set twice at one time.
  task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    tick();
    sfrWrEn = 1'b0;
    tick();
  endtask

  task automatic sfrRead(input logic [7:0] a, output logic [7:0] d);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    tick();
    sfrRdEn = 1'b0;
    tick();
    d = sfrRdData;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // The whole sequence needs under two thousand cycles.
  initial
  begin
    #(50 * 6000);
    badCount++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    `CHK(pins, expPins(RSTV))
    `CHK({bootSerialClock, bootSerialDataIn, masterDataIn, radioMode}, 5'h00)
    #2;
    nrst = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      tick();
      `CHK(pins, expPins(RSTV))
    end
    sfrRead(PORT, rd);
    `CHK(rd & 8'hFB, 8'h00)
    sfrRead(ROUTE, rd);
    `CHK(rd, 8'h00)
    sfrRead(8'h55, rd);
    `CHK(rd, 8'h00)
    // Chip enable stays low here so that no packet is started behind the bench.
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      sfrWrite(PORT, seed[7:0] & 8'hDF);
      `CHK(pins, expPins(seed[7:0] & 8'hDF))
      `CHK({bootSerialClock, bootSerialDataIn, masterDataIn}, 3'b000)
    end
    sfrWrite(PORT, 8'h08);
    sfrWrite(PORT, 8'h00);
    for (int i = 7; i >= 0; i--)
    begin
      repeat (4 + i) tick();
      sfrRead(PORT, rd);
      `CHK(rd[2], PATTERN[i])
      sfrWrite(PORT, 8'h01);
      sfrWrite(PORT, 8'h00);
    end
    sfrWrite(PORT, 8'h18);
    tick();
    `CHK(radioMode, 2'h0)
    sfrWrite(PORT, 8'h28);
    tick();
    `CHK(radioMode, 2'h1)
    packetOn = 1'b1;
    tick();
    packetOn = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      carrierOn = seed[0];
      eocOn = seed[1];
      repeat (4) tick();
      sfrRead(PORT, rd);
      `CHK(rd & 8'hFB, {1'b1, seed[0], 1'b1, seed[1], 4'h0})
    end
    carrierOn = 1'b0;
    sfrWrite(PORT, 8'h20);
    sfrWrite(PORT, 8'h28);
    repeat (4) tick();
    sfrRead(PORT, rd);
    `CHK(rd & 8'hFB, {4'h0, 1'b0, eocOn, 2'b00} << 2)
    sfrWrite(PORT, 8'h30);
    tick();
    `CHK(radioMode, 2'h2)
    sfrWrite(PORT, 8'h18);
    tick();
    `CHK(radioMode, 2'h2)
    for (int i = 0; i < 200 && radioMode === 2'h2; i++)
      tick();
    `CHK(radioMode, 2'h0)
    sfrRead(PORT, rd);
    `CHK(rd & 8'h20, 8'h20)
    // A select pulse clears ready so a second packet can start; then leave to receive.
    sfrWrite(PORT, 8'h10);
    sfrWrite(PORT, 8'h18);
    sfrWrite(PORT, 8'h30);
    tick();
    `CHK(radioMode, 2'h2)
    sfrWrite(PORT, 8'h28);
    for (int i = 0; i < 200 && radioMode === 2'h2; i++)
      tick();
    `CHK(radioMode, 2'h1)
    sfrWrite(PORT, 8'h10);
    sfrWrite(PORT, 8'h03);
    foreach (routes[k])
    begin
      seed = xs(seed);
      sfrWrite(ROUTE, {seed[7:2], routes[k]});
      sfrRead(ROUTE, rd);
      `CHK(rd, {6'h00, routes[k]})
      for (int i = 0; i < 6; i++)
      begin
        seed = xs(seed);
        masterClock = seed[0];
        masterDataOut = seed[1];
        bootSerialDataOut = seed[2];
        tick();
        `CHK({radioSerialClock, radioSerialDataIn}, routes[k][1] ? {seed[0], seed[1]} : 2'b11)
        `CHK({bootSerialClock, bootSerialDataIn}, (routes[k] === 2'h1) ? {seed[0], seed[1]} : 2'b00)
        `CHK(radioSerialSelect, 1'b0)
      end
      masterClock = 1'b0;
      bootSerialDataOut = 1'b1;
      repeat (5) tick();
      `CHK(masterDataIn, routes[k][1] ? radioSerialDataOut : (routes[k] === 2'h1))
    end
    sfrWrite(PORT, 8'h33);
    sfrWrite(ROUTE, 8'h02);
    nrst = 1'b0;
    #1;
    `CHK(pins, expPins(RSTV))
    `CHK({bootSerialClock, bootSerialDataIn, masterDataIn, radioMode}, 5'h00)
    repeat (3) tick();
    nrst = 1'b1;
    tick();
    `CHK(pins, expPins(RSTV))
    sfrRead(ROUTE, rd);
    `CHK(rd, 8'h00)
    results();
  end
endmodule // test_radio_control_port
